//--- flash_host_cfg.svh
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// Register byte offsets on the Wishbone side.
`define REG_CMD   8'h00
`define REG_CFG   8'h04
`define REG_ADDR  8'h08
`define REG_DATA  8'h0C
`define REG_STAT  8'h10
`define REG_RDATA 8'h14

// Status register bit positions.
`define STAT_ERR 1
`define STAT_TMO 8

// Unlock and parameter query addresses for word and byte width.
`define UNL_W1 12'h555
`define UNL_W2 12'h2AA
`define UNL_B1 12'hAAA
`define UNL_B2 12'h555
`define CFI_W  12'h055
`define CFI_B  12'h0AA

// Command codes.
`define CMD_UNL1   8'hAA
`define CMD_UNL2   8'h55
`define CMD_RESET  8'hF0
`define CMD_ID     8'h90
`define CMD_SEC    8'h88
`define CMD_ZERO   8'h00
`define CMD_PROG   8'hA0
`define CMD_BUF    8'h25
`define CMD_COMMIT 8'h29
`define CMD_BYP    8'h20
`define CMD_ERASE  8'h80
`define CMD_CHIP   8'h10
`define CMD_SECT   8'h30
`define CMD_SUSP   8'hB0
`define CMD_RESUME 8'h30
`define CMD_CFI    8'h98

// Program buffer size and page shift per width.
`define BUF_MAX_W  6'h10
`define BUF_MAX_B  6'h20
`define PAGE_SH_W  4
`define PAGE_SH_B  5

// Strobe timing.
`define CLK_PERIOD_NS 100
`define WE_LOW_NS     100
`define RD_LOW_NS     300
`define WE_LOW_CYC ((`WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_LOW_CYC ((`RD_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_DEPTH 2

`endif

//--- flash_host_pkg.sv
package flash_host_pkg;

	typedef enum logic [4:0] {
		OP_READ       = 5'h00,
		OP_RESET      = 5'h01,
		OP_ID_ENTER   = 5'h02,
		OP_SEC_ENTER  = 5'h03,
		OP_SEC_EXIT   = 5'h04,
		OP_PROGRAM    = 5'h05,
		OP_BUF_START  = 5'h06,
		OP_BUF_LOAD   = 5'h07,
		OP_BUF_COMMIT = 5'h08,
		OP_BUF_ABORT  = 5'h09,
		OP_BYP_ENTER  = 5'h0A,
		OP_BYP_PROG   = 5'h0B,
		OP_BYP_EXIT   = 5'h0C,
		OP_CHIP_ERASE = 5'h0D,
		OP_SECT_ERASE = 5'h0E,
		OP_SUSPEND    = 5'h0F,
		OP_RESUME     = 5'h10,
		OP_CFI        = 5'h11
	} op_e;

	typedef enum logic [1:0] {
		M_IDLE  = 2'b00,
		M_ISSUE = 2'b01,
		M_WAIT  = 2'b10
	} main_state_e;

	typedef enum logic [1:0] {
		C_IDLE  = 2'b00,
		C_SETUP = 2'b01,
		C_PULSE = 2'b10,
		C_HOLD  = 2'b11
	} cyc_state_e;

endpackage

//--- flash_cycle_if.sv
`timescale 1ns/1ps
interface flash_cycle_if #(parameter int AW = 22);
	logic          req;
	logic          rd;
	logic [AW-1:0] addr;
	logic [15:0]   wdata;
	logic          done;
	logic [15:0]   rdata;

	modport ctrl (output req, rd, addr, wdata, input done, rdata);
	modport eng  (input req, rd, addr, wdata, output done, rdata);
endinterface

//--- flash_cycle.sv
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_cycle #(
	parameter int AW = 22
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	flash_cycle_if.eng         bus,
	output logic [AW-1:0]      flash_addr_o,
	output logic [15:0]        flash_dq_o,
	output logic               flash_dq_oe_o,
	input  wire logic [15:0]   flash_dq_i,
	output logic               flash_ce_n_o,
	output logic               flash_we_n_o,
	output logic               flash_oe_n_o
);
	localparam logic [3:0] WE_CNT = 4'(`WE_LOW_CYC - 1);
	localparam logic [3:0] RD_CNT = 4'(`RD_LOW_CYC + `SYNC_DEPTH - 1);

	flash_host_pkg::cyc_state_e st_q, st_d;
	logic [3:0]    cnt_q, cnt_d;
	logic [AW-1:0] addr_q, addr_d;
	logic [15:0]   dat_q, dat_d, rdat_q, rdat_d, s1_q, s2_q;
	logic          rd_q, rd_d, ce_n_q, ce_n_d, we_n_q, we_n_d;
	logic          oe_n_q, oe_n_d, dqoe_q, dqoe_d;

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		addr_d = addr_q;
		dat_d  = dat_q;
		rd_d   = rd_q;
		ce_n_d = ce_n_q;
		we_n_d = we_n_q;
		oe_n_d = oe_n_q;
		dqoe_d = dqoe_q;
		rdat_d = rdat_q;
		case (st_q)
			flash_host_pkg::C_IDLE: begin
				if (bus.req) begin
					addr_d = bus.addr;
					dat_d  = bus.wdata;
					rd_d   = bus.rd;
					ce_n_d = 1'b0;
					dqoe_d = ~bus.rd;
					st_d   = flash_host_pkg::C_SETUP;
				end
			end
			// R18 strobe order: address settles before the write strobe falls.
			flash_host_pkg::C_SETUP: begin
				we_n_d = rd_q;
				oe_n_d = ~rd_q;
				cnt_d  = rd_q ? RD_CNT : WE_CNT;
				st_d   = flash_host_pkg::C_PULSE;
			end
			flash_host_pkg::C_PULSE: begin
				if (cnt_q == 4'h0) begin
					we_n_d = 1'b1;
					oe_n_d = 1'b1;
					if (rd_q) begin
						rdat_d = s2_q;
					end
					st_d = flash_host_pkg::C_HOLD;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			flash_host_pkg::C_HOLD: begin
				ce_n_d = 1'b1;
				dqoe_d = 1'b0;
				st_d   = flash_host_pkg::C_IDLE;
			end
			default: begin
				st_d = flash_host_pkg::C_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q   <= flash_host_pkg::C_IDLE;
			cnt_q  <= 4'h0;
			addr_q <= '0;
			dat_q  <= 16'h0000;
			rd_q   <= 1'b0;
			ce_n_q <= 1'b1;
			we_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			dqoe_q <= 1'b0;
			rdat_q <= 16'h0000;
			s1_q   <= 16'h0000;
			s2_q   <= 16'h0000;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			addr_q <= addr_d;
			dat_q  <= dat_d;
			rd_q   <= rd_d;
			ce_n_q <= ce_n_d;
			we_n_q <= we_n_d;
			oe_n_q <= oe_n_d;
			dqoe_q <= dqoe_d;
			rdat_q <= rdat_d;
			s1_q   <= flash_dq_i;
			s2_q   <= s1_q;
		end
	end

	assign bus.done      = (st_q == flash_host_pkg::C_HOLD);
	assign bus.rdata     = rdat_q;
	assign flash_addr_o  = addr_q;
	assign flash_dq_o    = dat_q;
	assign flash_dq_oe_o = dqoe_q;
	assign flash_ce_n_o  = ce_n_q;
	assign flash_we_n_o  = we_n_q;
	assign flash_oe_n_o  = oe_n_q;

	a_we_after_ce: assert property (@(posedge clk_i) disable iff (rst_i) // R18
		$fell(flash_we_n_o) |-> !flash_ce_n_o && $past(!flash_ce_n_o))
		else $error("write strobe fell without chip select settled");
	a_we_rise_first: assert property (@(posedge clk_i) disable iff (rst_i) // R18
		$rose(flash_ce_n_o) |-> flash_we_n_o && $past(flash_we_n_o))
		else $error("chip select rose before the write strobe");
	a_read_no_drive: assert property (@(posedge clk_i) disable iff (rst_i) // R4
		!flash_oe_n_o |-> !flash_dq_oe_o && flash_we_n_o)
		else $error("data bus driven during a read cycle");
endmodule

//--- flash_host.sv
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
// Functional notes
// R1: Word mode unlock is AA at 555, 55 at 2AA, command at 555.
// R2: Byte mode unlock is AA at AAA, 55 at 555, command at AAA.
// R3: Unlock cycles drive upper address bits and upper data bits as zero.
// R4: All sequence cycles are writes except array reads and ID reads.
// R5: Array reads in read mode need no unlock or command cycles.
// R6: F0 at any address resets; needed after ID mode or timeout.
// R7: The upper data byte of an ID read is don't care.
// R8: Part ID is three reads; software supplies each offset.
// R9: Secure region lock query returns one of four codes.
// R10: Sector group protect query returns zero or one.
// R11: Buffered program holds at most a full buffer of locations.
// R12: Count written after 25 equals locations minus one.
// R13: Every buffered location shares the first location's buffer page.
// R14: A write of 29 at the sector address commits the buffer.
// R15: Abort recovery is unlock plus F0; device becomes ready.
// R16: Bypass program needs bypass entry; it is A0 then data.
// R17: Leaving bypass takes 90 then 00 at any address.
// R18: Address latched at later strobe fall, data at earlier rise.
// R19: Suspend only during sector erase; reads, programs, ID allowed then.
// R20: Resume write of 30 accepted only while suspended.
// R21: Parameter query 98 at 55 or AA, only in read or ID mode.
// R22: Sector is selected by upper address bits only.
// R23: Erase is six writes ending 10 for chip or 30 for sector.
// R24: Single program is unlock pair, A0, then data at address.
module flash_host #(
	parameter int AW = 22
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic [31:0]        wb_dat_o,
	output logic               wb_ack_o,
	output logic [AW-1:0]      flash_addr_o,
	output logic [15:0]        flash_dq_o,
	output logic               flash_dq_oe_o,
	input  wire logic [15:0]   flash_dq_i,
	output logic               flash_ce_n_o,
	output logic               flash_we_n_o,
	output logic               flash_oe_n_o,
	output logic               flash_byte_n_o
);
	typedef flash_host_pkg::op_e op_t;

	flash_cycle_if #(.AW(AW)) cyc ();

	flash_cycle #(.AW(AW)) u_cycle (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.bus           (cyc.eng),
		.flash_addr_o  (flash_addr_o),
		.flash_dq_o    (flash_dq_o),
		.flash_dq_oe_o (flash_dq_oe_o),
		.flash_dq_i    (flash_dq_i),
		.flash_ce_n_o  (flash_ce_n_o),
		.flash_we_n_o  (flash_we_n_o),
		.flash_oe_n_o  (flash_oe_n_o)
	);

	flash_host_pkg::main_state_e st_q, st_d;
	op_t           op_q, op_d, cand, nop;
	logic [2:0]    step_q, step_d;
	logic [AW-1:0] addr_q, addr_d, page_q, page_d, pg, s_addr;
	logic [15:0]   data_q, data_d, rdat_q, rdat_d, s_data;
	logic [31:0]   dat_q, dat_d, wval;
	logic [5:0]    cnt_q, cnt_d, ld_q, ld_d, bmax;
	logic          byte_q, byte_d, auto_q, auto_d, ack_q, ack_d;
	logic          err_q, err_d, id_q, id_d, sec_q, sec_d, byp_q, byp_d;
	logic          susp_q, susp_d, ers_q, ers_d, buf_q, buf_d;
	logic          tmo_q, tmo_d, pend_q, pend_d;
	logic          wb_req, wr, ok, start, base, unl_op, s_rd, s_last;
	logic [11:0]   ua1, ua2;

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// R1 unlock addresses per width.
	assign ua1  = byte_q ? `UNL_B1 : `UNL_W1;
	// R2 byte mode shifts both unlock addresses.
	assign ua2  = byte_q ? `UNL_B2 : `UNL_W2;
	assign bmax = byte_q ? `BUF_MAX_B : `BUF_MAX_W;
	assign pg   = byte_q ? (addr_q >> `PAGE_SH_B) : (addr_q >> `PAGE_SH_W);
	assign unl_op = op_q inside {flash_host_pkg::OP_ID_ENTER,
		flash_host_pkg::OP_SEC_ENTER, flash_host_pkg::OP_SEC_EXIT,
		flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_BUF_START,
		flash_host_pkg::OP_BUF_ABORT, flash_host_pkg::OP_BYP_ENTER,
		flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECT_ERASE};

	// Step table: one bus cycle per step, upper bits zero where unused.
	always_comb begin
		s_rd   = 1'b0;
		s_last = 1'b0;
		s_addr = {{(AW-12){1'b0}}, ua1};
		s_data = {8'h00, `CMD_ZERO};
		// R3 unlock pair with clean upper bits.
		if (unl_op && step_q == 3'd0) begin
			s_data = {8'h00, `CMD_UNL1};
		end else if (unl_op && step_q == 3'd1) begin
			s_addr = {{(AW-12){1'b0}}, ua2};
			s_data = {8'h00, `CMD_UNL2};
		end else begin
			case (op_q)
				// R5 R8 plain read, ID offsets from software.
				flash_host_pkg::OP_READ: begin
					s_rd   = 1'b1;
					s_addr = addr_q;
					s_last = 1'b1;
				end
				// R6 reset at any address.
				flash_host_pkg::OP_RESET: begin
					s_addr = '0;
					s_data = {8'h00, `CMD_RESET};
					s_last = 1'b1;
				end
				flash_host_pkg::OP_ID_ENTER: begin
					s_data = {8'h00, `CMD_ID};
					s_last = 1'b1;
				end
				flash_host_pkg::OP_SEC_ENTER: begin
					s_data = {8'h00, `CMD_SEC};
					s_last = 1'b1;
				end
				flash_host_pkg::OP_SEC_EXIT: begin
					s_data = {8'h00, (step_q == 3'd2) ? `CMD_ID : `CMD_ZERO};
					s_addr = (step_q == 3'd2) ? s_addr : '0;
					s_last = (step_q == 3'd3);
				end
				// R24 single program.
				flash_host_pkg::OP_PROGRAM: begin
					s_data = (step_q == 3'd2) ? {8'h00, `CMD_PROG} : data_q;
					s_addr = (step_q == 3'd2) ? s_addr : addr_q;
					s_last = (step_q == 3'd3);
				end
				// R11 buffer command and R12 count, both at the sector.
				flash_host_pkg::OP_BUF_START: begin
					s_addr = addr_q;
					s_data = (step_q == 3'd2) ? {8'h00, `CMD_BUF} : data_q;
					s_last = (step_q == 3'd3);
				end
				flash_host_pkg::OP_BUF_LOAD: begin
					s_addr = addr_q;
					s_data = data_q;
					s_last = 1'b1;
				end
				// R14 commit at the sector address.
				flash_host_pkg::OP_BUF_COMMIT: begin
					s_addr = addr_q;
					s_data = {8'h00, `CMD_COMMIT};
					s_last = 1'b1;
				end
				// R15 abort recovery.
				flash_host_pkg::OP_BUF_ABORT: begin
					s_data = {8'h00, `CMD_RESET};
					s_last = 1'b1;
				end
				flash_host_pkg::OP_BYP_ENTER: begin
					s_data = {8'h00, `CMD_BYP};
					s_last = 1'b1;
				end
				// R16 two-cycle bypass program.
				flash_host_pkg::OP_BYP_PROG: begin
					s_addr = (step_q == 3'd0) ? '0 : addr_q;
					s_data = (step_q == 3'd0) ? {8'h00, `CMD_PROG} : data_q;
					s_last = (step_q == 3'd1);
				end
				// R17 bypass exit.
				flash_host_pkg::OP_BYP_EXIT: begin
					s_addr = '0;
					s_data = {8'h00, (step_q == 3'd0) ? `CMD_ID : `CMD_ZERO};
					s_last = (step_q == 3'd1);
				end
				// R23 six-write erase.
				flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECT_ERASE:
				begin
					case (step_q)
						3'd2: s_data = {8'h00, `CMD_ERASE};
						3'd3: s_data = {8'h00, `CMD_UNL1};
						3'd4: begin
							s_addr = {{(AW-12){1'b0}}, ua2};
							s_data = {8'h00, `CMD_UNL2};
						end
						default: begin
							s_last = 1'b1;
							if (op_q == flash_host_pkg::OP_SECT_ERASE) begin
								s_addr = addr_q;
								s_data = {8'h00, `CMD_SECT};
							end else begin
								s_data = {8'h00, `CMD_CHIP};
							end
						end
					endcase
				end
				flash_host_pkg::OP_SUSPEND, flash_host_pkg::OP_RESUME: begin
					s_addr = '0;
					s_data = {8'h00, (op_q == flash_host_pkg::OP_SUSPEND) ?
						`CMD_SUSP : `CMD_RESUME};
					s_last = 1'b1;
				end
				// R21 parameter query address per width.
				default: begin
					s_addr = {{(AW-12){1'b0}}, byte_q ? `CFI_B : `CFI_W};
					s_data = {8'h00, `CMD_CFI};
					s_last = 1'b1;
				end
			endcase
		end
	end

	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr     = wb_req & wb_we_i;
	assign cand   = op_t'(wb_dat_i[4:0]);
	assign base   = ~buf_q & ~byp_q & ~id_q;

	// Legality of a requested operation in the present mode.
	always_comb begin
		case (cand)
			flash_host_pkg::OP_READ:      ok = ~buf_q;
			flash_host_pkg::OP_RESET,
			flash_host_pkg::OP_ID_ENTER:  ok = ~buf_q & ~byp_q;
			// R19 programs stay legal while suspended.
			flash_host_pkg::OP_PROGRAM:   ok = base;
			flash_host_pkg::OP_SEC_ENTER, flash_host_pkg::OP_SEC_EXIT,
			flash_host_pkg::OP_BYP_ENTER, flash_host_pkg::OP_CHIP_ERASE,
			flash_host_pkg::OP_SECT_ERASE: ok = base & ~susp_q;
			// R11 count bounded by the buffer size.
			flash_host_pkg::OP_BUF_START: ok = base & ~susp_q &
				(data_q[5:0] < bmax) & (data_q[15:6] == 10'h000);
			// R13 same page as the first location.
			flash_host_pkg::OP_BUF_LOAD:  ok = buf_q & (ld_q <= cnt_q) &
				((ld_q == 6'h00) | (pg == page_q));
			// R12 commit only after count plus one loads.
			flash_host_pkg::OP_BUF_COMMIT: ok = buf_q &
				(ld_q == cnt_q + 6'h01);
			flash_host_pkg::OP_BUF_ABORT: ok = ~byp_q;
			flash_host_pkg::OP_BYP_PROG,
			flash_host_pkg::OP_BYP_EXIT:  ok = byp_q;
			// R19 suspend only over a sector erase.
			flash_host_pkg::OP_SUSPEND:   ok = ers_q & ~susp_q & ~buf_q;
			// R20 resume only while suspended.
			flash_host_pkg::OP_RESUME:    ok = susp_q;
			// R21 read mode or ID mode only.
			flash_host_pkg::OP_CFI:       ok = ~buf_q & ~byp_q & ~susp_q;
			default:                      ok = 1'b0;
		endcase
	end

	always_comb begin
		st_d = st_q; op_d = op_q; step_d = step_q; addr_d = addr_q;
		data_d = data_q; rdat_d = rdat_q; cnt_d = cnt_q; ld_d = ld_q;
		page_d = page_q; byte_d = byte_q; auto_d = auto_q;
		id_d = id_q; sec_d = sec_q; byp_d = byp_q; susp_d = susp_q;
		ers_d = ers_q; buf_d = buf_q; tmo_d = tmo_q; pend_d = pend_q;
		err_d = err_q; start = 1'b0; nop = cand;
		ack_d = wb_req;
		wval  = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
		case (wb_adr_i)
			`REG_CMD:   dat_d = {27'h0, op_q};
			`REG_CFG:   dat_d = {30'h0, auto_q, byte_q};
			`REG_ADDR:  dat_d = {{(32-AW){1'b0}}, addr_q};
			`REG_DATA:  dat_d = {16'h0, data_q};
			`REG_STAT:  dat_d = {10'h0, ld_q, 7'h0, tmo_q, buf_q, ers_q,
				susp_q, byp_q, sec_q, id_q, err_q,
				(st_q != flash_host_pkg::M_IDLE) | pend_q};
			`REG_RDATA: dat_d = {16'h0, rdat_q};
			default:    dat_d = 32'h0000_0000;
		endcase
		// Width and address are frozen while a sequence is on the pins.
		if (wr && st_q == flash_host_pkg::M_IDLE) begin
			if (wb_adr_i == `REG_CFG && wb_sel_i[0]) begin
				byte_d = wb_dat_i[0];
				auto_d = wb_dat_i[1];
			end
			if (wb_adr_i == `REG_ADDR) begin
				addr_d = AW'(merge({{(32-AW){1'b0}}, addr_q}, wb_dat_i,
					wb_sel_i));
			end
			if (wb_adr_i == `REG_DATA) begin
				data_d = 16'(merge({16'h0, data_q}, wb_dat_i, wb_sel_i));
			end
		end
		if (wr && wb_adr_i == `REG_STAT) begin
			err_d = err_q & ~wval[`STAT_ERR];
			tmo_d = tmo_q & ~wval[`STAT_TMO];
		end
		if (wr && wb_adr_i == `REG_CMD && wb_sel_i[0]) begin
			if (st_q == flash_host_pkg::M_IDLE && !pend_q && ok) begin
				start = 1'b1;
			end else begin
				err_d = 1'b1;
			end
		end
		// R6 queued reset after a timeout flag is seen.
		if (pend_q && st_q == flash_host_pkg::M_IDLE) begin
			start = 1'b1;
			nop   = flash_host_pkg::OP_RESET;
		end
		if (start) begin
			op_d = nop; step_d = 3'd0; st_d = flash_host_pkg::M_ISSUE;
			case (nop)
				flash_host_pkg::OP_RESET: begin
					id_d = 1'b0; pend_d = 1'b0; ers_d = ers_q & susp_q;
				end
				flash_host_pkg::OP_ID_ENTER:   id_d = 1'b1;
				flash_host_pkg::OP_SEC_ENTER:  sec_d = 1'b1;
				flash_host_pkg::OP_SEC_EXIT:   sec_d = 1'b0;
				flash_host_pkg::OP_BYP_ENTER:  byp_d = 1'b1;
				flash_host_pkg::OP_BYP_EXIT:   byp_d = 1'b0;
				flash_host_pkg::OP_SECT_ERASE: ers_d = 1'b1;
				flash_host_pkg::OP_CHIP_ERASE: ers_d = 1'b0;
				flash_host_pkg::OP_SUSPEND:    susp_d = 1'b1;
				flash_host_pkg::OP_RESUME:     susp_d = 1'b0;
				flash_host_pkg::OP_BUF_START: begin
					buf_d = 1'b1; cnt_d = data_q[5:0]; ld_d = 6'h00;
				end
				flash_host_pkg::OP_BUF_LOAD: begin
					ld_d = ld_q + 6'h01;
					page_d = (ld_q == 6'h00) ? pg : page_q;
				end
				flash_host_pkg::OP_BUF_COMMIT,
				flash_host_pkg::OP_BUF_ABORT:  buf_d = 1'b0;
				default: ;
			endcase
		end
		case (st_q)
			flash_host_pkg::M_ISSUE: st_d = flash_host_pkg::M_WAIT;
			flash_host_pkg::M_WAIT: begin
				if (cyc.done) begin
					// R7 upper byte of an ID read is don't care.
					if (s_rd) begin
						rdat_d = id_q ? {8'h00, cyc.rdata[7:0]} : cyc.rdata;
					end
					if (s_rd && auto_q && cyc.rdata[5] && !id_q) begin
						tmo_d = 1'b1; pend_d = 1'b1;
					end
					st_d   = s_last ? flash_host_pkg::M_IDLE :
						flash_host_pkg::M_ISSUE;
					step_d = s_last ? step_q : step_q + 3'd1;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= flash_host_pkg::M_IDLE; op_q <= flash_host_pkg::OP_READ;
			step_q <= 3'd0; addr_q <= '0; data_q <= 16'h0000;
			rdat_q <= 16'h0000; cnt_q <= 6'h00; ld_q <= 6'h00;
			page_q <= '0; byte_q <= 1'b0; auto_q <= 1'b0; ack_q <= 1'b0;
			err_q <= 1'b0; id_q <= 1'b0; sec_q <= 1'b0; byp_q <= 1'b0;
			susp_q <= 1'b0; ers_q <= 1'b0; buf_q <= 1'b0; tmo_q <= 1'b0;
			pend_q <= 1'b0; dat_q <= 32'h0000_0000;
		end else begin
			st_q <= st_d; op_q <= op_d; step_q <= step_d; addr_q <= addr_d;
			data_q <= data_d; rdat_q <= rdat_d; cnt_q <= cnt_d;
			ld_q <= ld_d; page_q <= page_d; byte_q <= byte_d;
			auto_q <= auto_d; ack_q <= ack_d; err_q <= err_d; id_q <= id_d;
			sec_q <= sec_d; byp_q <= byp_d; susp_q <= susp_d;
			ers_q <= ers_d; buf_q <= buf_d; tmo_q <= tmo_d;
			pend_q <= pend_d; dat_q <= dat_d;
		end
	end

	assign cyc.req        = (st_q == flash_host_pkg::M_ISSUE);
	assign cyc.rd         = s_rd;
	assign cyc.addr       = s_addr;
	assign cyc.wdata      = s_data;
	assign wb_ack_o       = ack_q;
	assign wb_dat_o       = dat_q;
	assign flash_byte_n_o = ~byte_q;

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");
	a_unlock_head: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		cyc.req && unl_op && step_q == 3'd0 |-> flash_we_n_o [*2] ##1
		!flash_we_n_o && flash_dq_o == 16'h00AA &&
		flash_addr_o[11:0] == (byte_q ? 12'hAAA : 12'h555))
		else $error("unlock sequence did not open with AA at unlock address");
	a_byte_second: assert property (@(posedge clk_i) disable iff (rst_i) // R2
		cyc.req && unl_op && step_q == 3'd1 && byte_q |-> ##2
		flash_addr_o[11:0] == 12'h555 && flash_dq_o == 16'h0055)
		else $error("byte mode second unlock cycle wrong");
	a_unlock_clean: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		cyc.req && unl_op && step_q < 3'd2 |-> ##2
		flash_addr_o[AW-1:12] == '0 && flash_dq_o[15:8] == 8'h00)
		else $error("upper bits not zero during unlock");
	a_cfi_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R21
		start && nop == flash_host_pkg::OP_CFI |-> !byp_q && !susp_q &&
		!buf_q)
		else $error("parameter query issued outside read or ID mode");
	a_resume_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R20
		start && nop == flash_host_pkg::OP_RESUME |-> susp_q ##1 !susp_q)
		else $error("resume issued while not suspended");
	a_commit_count: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		start && nop == flash_host_pkg::OP_BUF_COMMIT |->
		ld_q == cnt_q + 6'h01 ##1 !buf_q)
		else $error("commit with wrong number of loads");
	a_bypass_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R16
		start && nop == flash_host_pkg::OP_BYP_PROG |-> byp_q)
		else $error("bypass program outside bypass mode");
	a_suspend_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		start && nop == flash_host_pkg::OP_SUSPEND |-> ers_q && !susp_q)
		else $error("suspend issued without a sector erase");
	a_timeout_reset: assert property (@(posedge clk_i) disable iff (rst_i) // R6
		$rose(pend_q) |-> ##[1:40] (cyc.req &&
		op_q == flash_host_pkg::OP_RESET))
		else $error("timeout reset not issued");
endmodule

//--- flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model (
	input  wire logic [21:0] addr_i,
	input  wire logic [15:0] dq_i,
	input  wire logic        ce_n_i,
	input  wire logic        we_n_i,
	input  wire logic        oe_n_i,
	output logic      [15:0] dq_o
);
	logic [37:0] log_q[$];
	logic [21:0] pa_q;
	logic [15:0] last_q = 16'h0000;
	logic        id_q = 1'b0;
	logic [15:0] rd_v;
	always @(negedge we_n_i) if (!ce_n_i) pa_q = addr_i;
	always @(posedge we_n_i) begin
		if (!ce_n_i) begin
			log_q.push_back({pa_q, dq_i});
			id_q = (dq_i[7:0] == 8'h90) | (id_q & (dq_i[7:0] != 8'hF0));
		end
	end
	// query answers: lock code at 03, sector 05 protected.
	// The upper byte carries noise so that the host must mask it.
	assign rd_v = !id_q ? addr_i[15:0] ^ 16'hA5C3 :
		(addr_i[1:0] == 2'h3) ? 16'hFF98 :
		{15'h7F80, addr_i[20:15] == 6'h05};
	always @(posedge oe_n_i) last_q = rd_v;
	// array data unlocked
	// A released bus shows the inverse of the last word, never a stale copy.
	assign dq_o = (!ce_n_i && !oe_n_i) ? rd_v : ~last_q;
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        cyc = 0;
	logic        stb = 0;
	logic        we = 0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rd;
	logic        ack;
	logic [21:0] fa;
	logic [15:0] fo;
	logic [15:0] fi;
	logic        oe;
	logic        ce_n;
	logic        we_n;
	logic        oe_n;
	logic        byte_n;
	logic [31:0] q;
	int          n_fail = 0;
	int          comparisons = 0;
	always #50 clk_i = ~clk_i;
	flash_host u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .flash_addr_o(fa),
		.flash_dq_o(fo), .flash_dq_oe_o(oe), .flash_dq_i(fi),
		.flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n),
		.flash_byte_n_o(byte_n));
	flash_dev_model u_dev (.addr_i(fa), .dq_i(fo), .ce_n_i(ce_n),
		.we_n_i(we_n), .oe_n_i(oe_n), .dq_o(fi));
	// data driven while the write strobe rises.
	always @(posedge we_n) if (!ce_n) chk(38'(oe), 38'h1);
	task automatic wrap_up;
		if (n_fail == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [37:0] got, input logic [37:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic run(input logic [4:0] op, input logic [21:0] a,
		input logic [15:0] d);
		u_dev.log_q.delete();
		wb(1'b1, 8'h08, {10'h0, a});
		wb(1'b1, 8'h0C, {16'h0, d});
		wb(1'b1, 8'h00, {27'h0, op});
		for (int i = 0; i < 100; i++) begin
			wb(1'b0, 8'h10, 32'h0);
			if (q[0] === 1'b0) break;
		end
		chk(38'(q[0]), 38'h0);
	endtask
	task automatic seq(input logic [37:0] e[$]);
		chk(38'(u_dev.log_q.size()), 38'(e.size()));
		foreach (e[i]) chk(u_dev.log_q[i], e[i]);
	endtask
	task automatic t_prog;
		run(5'h05, 22'h001234, 16'hBEEF);
		seq('{{22'h555, 16'h00AA}, {22'h2AA, 16'h0055},
			{22'h555, 16'h00A0}, {22'h001234, 16'hBEEF}});
	endtask
	task automatic t_buf;
		run(5'h06, 22'h008000, 16'h0001);
		seq('{{22'h555, 16'h00AA}, {22'h2AA, 16'h0055},
			{22'h008000, 16'h0025}, {22'h008000, 16'h0001}});
		// both loads stay inside the first location's page.
		for (int k = 0; k < 2; k++) begin
			run(5'h07, 22'h008010 + 22'(k), 16'h1111 << k);
			seq('{{22'h008010 + 22'(k), 16'h1111 << k}});
		end
		run(5'h08, 22'h008000, 16'h0);
		seq('{{22'h008000, 16'h0029}});
	endtask
	task automatic t_erase;
		wb(1'b1, 8'h04, 32'h1);
		run(5'h0D, 22'h0, 16'h0);
		chk(38'(byte_n), 38'h0);
		seq('{{22'hAAA, 16'h00AA}, {22'h555, 16'h0055},
			{22'hAAA, 16'h0080}, {22'hAAA, 16'h00AA},
			{22'h555, 16'h0055}, {22'hAAA, 16'h0010}});
		wb(1'b1, 8'h04, 32'h0);
	endtask
	task automatic t_read;
		run(5'h00, 22'h000321, 16'h0);
		wb(1'b0, 8'h14, 32'h0);
		chk(38'(q[15:0]), 38'(16'h0321 ^ 16'hA5C3));
		chk(38'(u_dev.log_q.size()), 38'h0);
		// A read showing the timeout flag must trigger a reset write.
		wb(1'b1, 8'h04, 32'h2);
		run(5'h00, 22'h000020, 16'h0);
		chk(38'(q[8]), 38'h1);
		chk(u_dev.log_q[0], {22'h0, 16'h00F0});
		wb(1'b1, 8'h10, 32'h100);
		wb(1'b1, 8'h04, 32'h0);
	endtask
	task automatic t_id;
		run(5'h02, 22'h0, 16'h0);
		run(5'h00, 22'h000003, 16'h0);
		wb(1'b0, 8'h14, 32'h0);
		chk(38'(q), 38'h98);
		for (int k = 0; k < 2; k++) begin
			run(5'h00, 22'h020002 | (22'(k) << 15), 16'h0);
			wb(1'b0, 8'h14, 32'h0);
			chk(38'(q), 38'(k));
		end
		run(5'h01, 22'h0, 16'h0);
	endtask
	task automatic t_reset;
		run(5'h01, 22'h0, 16'h0);
		chk(38'(u_dev.log_q.size()), 38'h1);
		chk(38'(u_dev.log_q[0][15:0]), 38'hF0);
	endtask
	task automatic t_refuse;
		// Suspend and resume with no erase running must stay off the bus.
		for (int k = 0; k < 2; k++) begin
			run(k ? 5'h10 : 5'h0F, 22'h0, 16'h0);
			chk(38'(q[1]), 38'h1);
			chk(38'(u_dev.log_q.size()), 38'h0);
			wb(1'b1, 8'h10, 32'h2);
		end
		wb(1'b0, 8'h20, 32'h0);
		chk(38'(q), 38'h0);
	endtask
	initial begin
		#3000000;
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_prog();
		t_buf();
		t_erase();
		t_read();
		t_id();
		t_reset();
		t_refuse();
		wrap_up();
	end
endmodule
